// >>> verilog/ppm_defs.svh
/*
 * Constants of the path alarm monitor: clock rates, persistence
 * counts, bit positions and serial alarm frame layout.
 * Assumes inclusion once per compilation unit, by bare name.
 */
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH

// Clock rates in hertz
`define PPM_SYS_CLK_HZ   25000000
`define PPM_OH_CLK_HZ    576000
// Half period of the overhead clock in system cycles
`define PPM_OH_HALF      (`PPM_SYS_CLK_HZ / (2 * `PPM_OH_CLK_HZ))

// Persistence counts in frames
`define PPM_CNT_W        4
`define PPM_LOP_SET      4'h8
`define PPM_LOP_CLR      4'h3
`define PPM_AIS_SET      4'h3
`define PPM_AIS_CLR      4'h3
`define PPM_FERF_CNT     4'h5

// Parity and status byte layout
`define PPM_BIP_BITS     8
`define PPM_BIP_CNT_W    4
`define PPM_G1_FERF_BIT  3
`define PPM_PTR_W        10

// Serial alarm frame: eight groups of nine slots, three carry data
`define PPM_SLOT_W       4
`define PPM_GRP_W        3
`define PPM_SLOT_LAST    4'h8
`define PPM_GRP_LAST     3'h7
`define PPM_GRP_USED     3'h3
`define PPM_SLOT_FERF    4'h8

`endif

// >>> verilog/ppm_pkg.sv
/*
 * Types of the path alarm monitor.
 * Assumes nothing of its surroundings.
 */
package ppm_pkg;

    typedef enum logic [1:0]
    {
        PPM_MODE_STS1,
        PPM_MODE_STS3C,
        PPM_MODE_3XSTS1
    } ppm_mode_t;

endpackage

// >>> verilog/ppm_ptr_alarm.sv
/*
 * Per-stream pointer loss, path AIS and far-end failure states.
 * Assumes frame_en is one cycle per frame, on a line clock enable.
 */
`timescale 1ns/1ps
`include "ppm_defs.svh"

module ppm_ptr_alarm
    import ppm_pkg::*;
(
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // Frame pointer report
    input  wire logic                   frame_en,
    input  wire logic                   ptr_valid,
    input  wire logic [`PPM_PTR_W-1:0]  ptr_value,
    input  wire logic                   new_data_flag,
    input  wire logic                   ptr_ones,
    input  wire logic [7:0]             g1_byte,
    // Alarm states
    output logic                        lop_q,
    output logic                        ais_q,
    output logic                        ferf_q
);

    logic [`PPM_CNT_W-1:0]  inv_q, ndf_q, same_q, ones_q, hi_q, lo_q;
    logic [`PPM_CNT_W-1:0]  inv_d, ndf_d, same_d, ones_d, hi_d, lo_d;
    logic [`PPM_PTR_W-1:0]  last_q;
    wire                    same_ok = ptr_valid & ~new_data_flag;
    wire                    ferf_bit = g1_byte[`PPM_G1_FERF_BIT];

    function automatic logic [`PPM_CNT_W-1:0] inc(
        input logic [`PPM_CNT_W-1:0] c
    );
        inc = (c == `PPM_LOP_SET) ? c : c + 4'h1;
    endfunction

    // Counters restart on any frame breaking their condition
    assign inv_d  = ~ptr_valid ? inc(inv_q) : 4'h0;
    assign ndf_d  = (ptr_valid & new_data_flag) ? inc(ndf_q) : 4'h0;
    assign same_d = ~same_ok ? 4'h0 :
                    (ptr_value == last_q) ? inc(same_q) : 4'h1;
    assign ones_d = ptr_ones ? inc(ones_q) : 4'h0;
    assign hi_d   = ferf_bit ? inc(hi_q) : 4'h0;
    assign lo_d   = ~ferf_bit ? inc(lo_q) : 4'h0;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            {inv_q, ndf_q, same_q, ones_q, hi_q, lo_q} <= '0;
            last_q <= '0;
        end
        else if (frame_en)
        begin
            {inv_q, ndf_q, same_q} <= {inv_d, ndf_d, same_d};
            {ones_q, hi_q, lo_q} <= {ones_d, hi_d, lo_d};
            if (ptr_valid)
                last_q <= ptr_value;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            lop_q  <= 1'b0;
            ais_q  <= 1'b0;
            ferf_q <= 1'b0;
        end
        else if (frame_en)
        begin
            if (inv_d == `PPM_LOP_SET || ndf_d == `PPM_LOP_SET)
                lop_q <= 1'b1;
            else if (same_d == `PPM_LOP_CLR)
                lop_q <= 1'b0;
            if (ones_d == `PPM_AIS_SET)
                ais_q <= 1'b1;
            else if (same_d == `PPM_AIS_CLR ||
                     (ptr_valid & new_data_flag))
                ais_q <= 1'b0;
            if (hi_d == `PPM_FERF_CNT)
                ferf_q <= 1'b1;
            else if (lo_d == `PPM_FERF_CNT)
                ferf_q <= 1'b0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_lop_set_eight: assert property (
        frame_en && ~ptr_valid && inv_q == 4'h7 |=> lop_q)
        else $error("pointer loss not raised after eight frames");
    a_lop_clear_three: assert property (
        frame_en && same_ok && ptr_value == last_q &&
        same_q == 4'h2 && inv_d != `PPM_LOP_SET |=> !lop_q)
        else $error("pointer loss not cleared after three frames");
    a_ais_set_three: assert property (
        frame_en && ptr_ones && ones_q == 4'h2 |=> ais_q)
        else $error("path ais not raised after three frames");
    a_ais_ndf_clear: assert property (
        frame_en && ptr_valid && new_data_flag &&
        ones_d != `PPM_AIS_SET |=> !ais_q)
        else $error("path ais not cleared by valid pointer with flag");
    a_ferf_set_five: assert property (
        frame_en && ferf_bit && hi_q == 4'h4 |=> ferf_q)
        else $error("far end failure not raised after five frames");
    a_ferf_clear_five: assert property (
        frame_en && !ferf_bit && lo_q == 4'h4 |=> !ferf_q)
        else $error("far end failure not cleared after five frames");

endmodule

// >>> verilog/ppm_bip_check.sv
/*
 * Per-stream path parity check and error pulse queue.
 * Assumes byte_en marks path payload bytes, frame_start the first.
 */
`timescale 1ns/1ps
`include "ppm_defs.svh"

module ppm_bip_check
    import ppm_pkg::*;
(
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    // Path payload bytes
    input  wire logic                      byte_en,
    input  wire logic [7:0]                byte_data,
    input  wire logic                      frame_start,
    input  wire logic                      b3_en,
    // Control and timing
    input  wire logic                      block_mode,
    input  wire logic                      ovh_fall,
    // Results
    output logic                           err_pulse_q,
    output logic [`PPM_BIP_CNT_W-1:0]      errs_q
);

    logic [7:0]                  acc_q, prev_q;
    logic [`PPM_BIP_CNT_W-1:0]   pend_q;
    wire  [7:0]                  mism = byte_data ^ prev_q;
    logic [`PPM_BIP_CNT_W-1:0]   ones;
    wire                         check = byte_en & b3_en;
    wire  [`PPM_BIP_CNT_W-1:0]   load = block_mode ?
                                 {3'h0, |mism} : ones;

    always_comb
    begin
        ones = '0;
        for (int i = 0; i < `PPM_BIP_BITS; i++)
            ones = ones + {3'h0, mism[i]};
    end

    // Parity of previous frame kept against the received B3
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            acc_q  <= '0;
            prev_q <= '0;
        end
        else if (byte_en)
        begin
            acc_q <= frame_start ? byte_data : acc_q ^ byte_data;
            if (frame_start)
                prev_q <= acc_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pend_q      <= '0;
            errs_q      <= '0;
            err_pulse_q <= 1'b0;
        end
        else
        begin
            if (check)
            begin
                pend_q <= load;
                errs_q <= load;
            end
            else if (ovh_fall && pend_q != '0)
                pend_q <= pend_q - 4'h1;
            if (ovh_fall)
                err_pulse_q <= (pend_q != '0);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_pend_at_most: assert property (
        pend_q <= `PPM_BIP_BITS)
        else $error("more than eight error pulses queued");
    a_block_single: assert property (
        check && block_mode |=> errs_q == {3'h0, |$past(mism)})
        else $error("block mode count not one per frame");
    a_bit_count: assert property (
        check && !block_mode && mism == 8'hff |=> errs_q == 4'h8)
        else $error("bit mode count wrong for all bits bad");

endmodule

// >>> verilog/ppm_monitor.sv
/*
 * Path alarm monitor top: overhead clocks, parity error pulses,
 * serial alarm port and line-side alarm outputs for three streams.
 * Assumes line_clk_en marks rising line-side clock edges and that
 * all inputs are synchronous to sys_clk.
 */
// What this block does
// - Bit mode gives one parity pulse per bad bit, at most eight.
// - Block mode gives one parity pulse per frame on any mismatch.
// - Received B3 is compared with parity of the previous frame.
// - Parity pulses change only on overhead clock falling edges, or at once when external termination clears them.
// - Serial port sends error counts and failure state on falls.
// - Pointer loss rises after eight invalid or eight flagged frames.
// - Pointer loss clears after three equal valid unflagged pointers.
// - Concatenated mode uses only the first pointer pair.
// - Path AIS rises after three all-ones pointer frames.
// - AIS clears on three equal pointers or one flagged valid.
// - Far-end failure rises after five frames with status bit set.
// - Far-end failure clears after five frames with bit clear.
// - Single-stream modes drive only stream one outputs.
// - Pointer, AIS and failure outputs change on line clock edges.
// - External termination holds every alarm output inactive.
// - Overhead clocks run near 576 kHz, one per stream.
// - Frame mark is high on the first stream-one error slot.
`timescale 1ns/1ps
`include "ppm_defs.svh"

module ppm_monitor
    import ppm_pkg::*;
#(
    parameter int OH_HALF = `PPM_OH_HALF
)
(
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    // Mode control
    input  wire ppm_mode_t                 mode,
    input  wire logic                      block_mode,
    input  wire logic                      ext_term_en,
    // Line-side timing
    input  wire logic                      line_clk_en,
    // Per-stream frame pointer reports
    input  wire logic [2:0]                frame_tick,
    input  wire logic [2:0]                ptr_valid,
    input  wire logic [2:0][9:0]           ptr_value,
    input  wire logic [2:0]                new_data_flag,
    input  wire logic [2:0]                ptr_ones,
    input  wire logic [2:0][7:0]           g1_byte,
    // Per-stream path payload bytes
    input  wire logic [2:0]                spe_byte_en,
    input  wire logic [2:0][7:0]           spe_byte,
    input  wire logic [2:0]                spe_start,
    input  wire logic [2:0]                spe_b3,
    // Overhead timing outputs
    output logic [2:0]                     overhead_clock_q,
    output logic [2:0]                     overhead_frame_mark_q,
    // Alarm outputs
    output logic [2:0]                     parity_error_pulse_q,
    output logic                           serial_alarm_out_q,
    output logic [2:0]                     pointer_loss_flag_q,
    output logic [2:0]                     path_ais_flag_q,
    output logic [2:0]                     far_end_fail_flag_q
);

    localparam int DIV_W = 8;

    if (OH_HALF < 2 || OH_HALF >= (1 << DIV_W))
    begin : g_bad_div
        $error("OH_HALF out of range");
    end

    // Divider and stream activity
    logic [DIV_W-1:0]          div_q;
    logic                      ohclk_q;
    wire                       div_wrap = (div_q == DIV_W'(OH_HALF - 1));
    wire                       ovh_fall = div_wrap & ohclk_q;
    wire                       multi = (mode == PPM_MODE_3XSTS1);
    wire  [2:0]                act = multi ? 3'h7 : 3'h1;
    wire                       quiet = ext_term_en;

    // Per-stream results
    wire  [2:0]                lop_s, ais_s, ferf_s, pulse_s;
    wire  [2:0][3:0]           errs_s;
    wire  [2:0]                frame_en = frame_tick & {3{line_clk_en}};

    // Overhead clock divider
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            div_q   <= '0;
            ohclk_q <= 1'b0;
        end
        else
        begin
            div_q <= div_wrap ? '0 : div_q + DIV_W'(1);
            if (div_wrap)
                ohclk_q <= ~ohclk_q;
        end
    end

    // Per-stream state and parity checks
    for (genvar s = 0; s < 3; s++)
    begin : g_stream
        // Concatenated mode reads only the first pointer pair
        ppm_ptr_alarm u_ptr (
            .sys_clk       (sys_clk),
            .rst           (rst),
            .frame_en      (frame_en[s] & act[s]),
            .ptr_valid     (ptr_valid[s]),
            .ptr_value     (ptr_value[s]),
            .new_data_flag (new_data_flag[s]),
            .ptr_ones      (ptr_ones[s]),
            .g1_byte       (g1_byte[s]),
            .lop_q         (lop_s[s]),
            .ais_q         (ais_s[s]),
            .ferf_q        (ferf_s[s])
        );

        ppm_bip_check u_bip (
            .sys_clk       (sys_clk),
            .rst           (rst),
            .byte_en       (spe_byte_en[s] & line_clk_en),
            .byte_data     (spe_byte[s]),
            .frame_start   (spe_start[s]),
            .b3_en         (spe_b3[s]),
            .block_mode    (block_mode),
            .ovh_fall      (ovh_fall),
            .err_pulse_q   (pulse_s[s]),
            .errs_q        (errs_s[s])
        );
    end

    // Serial alarm slot counters
    logic [`PPM_SLOT_W-1:0]    slot_q;
    logic [`PPM_GRP_W-1:0]     grp_q;
    wire                       slot_wrap = (slot_q == `PPM_SLOT_LAST);
    wire                       grp_data = (grp_q < `PPM_GRP_USED);
    wire  [1:0]                grp_idx = grp_q[1:0];
    wire  [3:0]                grp_errs = errs_s[grp_idx];
    wire                       grp_live = grp_data & act[grp_idx];
    wire                       err_bit = (slot_q < grp_errs);
    wire                       ferf_bit = far_end_fail_flag_q[grp_idx];
    wire                       rad_d = grp_live &
                               ((slot_q == `PPM_SLOT_FERF) ?
                                ferf_bit : err_bit);
    wire  [`PPM_SLOT_W-1:0]    slot_n = slot_wrap ? '0 :
                               slot_q + `PPM_SLOT_W'(1);
    wire  [`PPM_GRP_W-1:0]     grp_n = !slot_wrap ? grp_q :
                               (grp_q == `PPM_GRP_LAST) ? '0 :
                               grp_q + `PPM_GRP_W'(1);
    // Mark travels with the slot now sent
    wire                       mark_n = (slot_q == '0) & (grp_q == '0);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            slot_q <= '0;
            grp_q  <= '0;
        end
        else if (ovh_fall)
        begin
            slot_q <= slot_n;
            grp_q  <= grp_n;
        end
    end

    // Overhead clock, and overhead-clocked outputs changed on falling edges
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            overhead_clock_q      <= '0;
            overhead_frame_mark_q <= '0;
            parity_error_pulse_q  <= '0;
            serial_alarm_out_q    <= 1'b0;
        end
        else
        begin
            overhead_clock_q <= quiet ? '0 :
                                div_wrap ? {3{~ohclk_q}} & act :
                                overhead_clock_q & act;
            if (ovh_fall)
            begin
                overhead_frame_mark_q <= quiet ? '0 :
                                         {2'h0, mark_n};
                parity_error_pulse_q  <= quiet ? '0 :
                                         pulse_s & act;
                serial_alarm_out_q    <= ~quiet & rad_d;
            end
            else if (quiet)
            begin
                overhead_frame_mark_q <= '0;
                parity_error_pulse_q  <= '0;
                serial_alarm_out_q    <= 1'b0;
            end
        end
    end

    // Line-side alarm outputs
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pointer_loss_flag_q <= '0;
            path_ais_flag_q     <= '0;
            far_end_fail_flag_q <= '0;
        end
        else if (line_clk_en)
        begin
            pointer_loss_flag_q <= quiet ? '0 : lop_s & act;
            path_ais_flag_q     <= quiet ? '0 : ais_s & act;
            far_end_fail_flag_q <= quiet ? '0 : ferf_s & act;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ext_quiet_all: assert property (
        ext_term_en [*2] |-> parity_error_pulse_q == '0 &&
        !serial_alarm_out_q && overhead_frame_mark_q == '0)
        else $error("overhead outputs active under external mode");
    a_ext_quiet_line: assert property (
        ext_term_en && line_clk_en |=> pointer_loss_flag_q == '0 &&
        path_ais_flag_q == '0 && far_end_fail_flag_q == '0)
        else $error("line alarms active under external mode");
    a_pulse_on_fall: assert property (
        $changed(parity_error_pulse_q) |-> $past(ovh_fall) ||
        $past(quiet))
        else $error("parity pulse changed off a falling edge");
    a_serial_on_fall: assert property (
        $changed(serial_alarm_out_q) |-> $past(ovh_fall) ||
        $past(quiet))
        else $error("serial alarm changed off a falling edge");
    a_alarm_line_edge: assert property (
        $changed({pointer_loss_flag_q, path_ais_flag_q,
                  far_end_fail_flag_q}) |-> $past(line_clk_en))
        else $error("line alarm changed off a line clock edge");
    a_single_stream: assert property (
        !multi [*2] |-> pointer_loss_flag_q[2:1] == '0 &&
        path_ais_flag_q[2:1] == '0 && overhead_clock_q[2:1] == '0)
        else $error("stream two or three active in single mode");
    a_mark_first: assert property (
        overhead_frame_mark_q[0] |-> grp_q == '0 &&
        slot_q == `PPM_SLOT_W'(1))
        else $error("frame mark away from first error slot");
    a_ohclk_rate: assert property (
        $changed(ohclk_q) |-> $past(div_q) == DIV_W'(OH_HALF - 1))
        else $error("overhead clock toggled at wrong count");

    c_lop_raised: cover property (
        $rose(pointer_loss_flag_q[0]));
    c_ais_cleared: cover property (
        $fell(path_ais_flag_q[0]));
    c_ferf_serial: cover property (
        serial_alarm_out_q && slot_q == `PPM_SLOT_W'(0));
    c_parity_pulse: cover property (
        $rose(parity_error_pulse_q[0]));

endmodule

// >>> verif/ppm_collector.sv
/*
 * Downstream alarm collector: counts parity pulse periods and captures
 * the stream-one group of the serial alarm frame.
 * Assumes sampling on overhead clock rises, mid-period of each slot.
 */
`timescale 1ns/1ps

module ppm_collector
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Monitor outputs
    input  wire logic        ovh_clk,
    input  wire logic        frame_mark,
    input  wire logic        err_pulse,
    input  wire logic        serial_in,
    // Control and results
    input  wire logic        clr,
    output logic [7:0]       pulse_cnt_q,
    output logic [8:0]       slot_bits_q
);
    logic       ovh_q;
    logic [6:0] slot_q;
    wire        ovh_rise = ovh_clk & ~ovh_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ovh_q       <= 1'b0;
            slot_q      <= 7'h7f;
            pulse_cnt_q <= 8'h00;
            slot_bits_q <= 9'h000;
        end
        else
        begin
            ovh_q <= ovh_clk;
            if (clr)
                pulse_cnt_q <= 8'h00;
            else if (ovh_rise && err_pulse)
                pulse_cnt_q <= pulse_cnt_q + 8'h01;
            if (ovh_rise)
            begin
                slot_q <= frame_mark ? 7'h01 : slot_q + 7'h01;
                if (frame_mark)
                    slot_bits_q[0] <= serial_in;
                else if (slot_q < 7'h09)
                    slot_bits_q[slot_q[3:0]] <= serial_in;
            end
        end
    end
endmodule

// >>> verif/ppm_monitor_tb.sv
/*
 * Self-checking bench of the path alarm monitor.
 * Assumes the design package and defines header are compiled first.
 */
`timescale 1ns/1ps
`include "ppm_defs.svh"

module ppm_monitor_tb;
    import ppm_pkg::*;
    localparam int HALF = 2;
    logic            sys_clk, rst, block_mode, ext_term_en, line_clk_en;
    ppm_mode_t       mode;
    logic [2:0]      frame_tick, ptr_valid, new_data_flag, ptr_ones;
    logic [2:0]      spe_byte_en, spe_start, spe_b3;
    logic [2:0][9:0] ptr_value;
    logic [2:0][7:0] g1_byte, spe_byte;
    logic [2:0]      ovh, mark, perr, pointer_loss_flag, ais, ferf;
    logic            serial_alarm_out, clr;
    logic [7:0]      pcnt, par;
    logic [8:0]      slots;
    int              error_cnt, n_compared;

    ppm_monitor #(.OH_HALF(HALF)) u_ppm_monitor (.sys_clk(sys_clk),
        .rst(rst), .mode(mode), .block_mode(block_mode),
        .ext_term_en(ext_term_en), .line_clk_en(line_clk_en),
        .frame_tick(frame_tick), .ptr_valid(ptr_valid),
        .ptr_value(ptr_value), .new_data_flag(new_data_flag),
        .ptr_ones(ptr_ones), .g1_byte(g1_byte), .spe_byte_en(spe_byte_en),
        .spe_byte(spe_byte), .spe_start(spe_start), .spe_b3(spe_b3),
        .overhead_clock_q(ovh), .overhead_frame_mark_q(mark),
        .parity_error_pulse_q(perr), .serial_alarm_out_q(serial_alarm_out),
        .pointer_loss_flag_q(pointer_loss_flag), .path_ais_flag_q(ais),
        .far_end_fail_flag_q(ferf));
    ppm_collector u_ppm_collector (.sys_clk(sys_clk), .rst(rst),
        .ovh_clk(ovh[0]), .frame_mark(mark[0]), .err_pulse(perr[0]),
        .serial_in(serial_alarm_out), .clr(clr), .pulse_cnt_q(pcnt),
        .slot_bits_q(slots));

    task automatic chk(input logic [8:0] got, exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            $display("BAD %0t %s", $time, m);
            error_cnt++;
        end
    endtask
    task automatic stop_test();
        $display("errors %0d compares %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic rep(input int s, input logic v, input logic [9:0] pv,
                       input logic nd, on, fb, input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            frame_tick[s] <= 1'b1;
            ptr_valid[s] <= v;
            ptr_value[s] <= pv;
            new_data_flag[s] <= nd;
            ptr_ones[s] <= on;
            g1_byte[s] <= {4'h0, fb, 3'h0};
            @(posedge sys_clk);
            frame_tick[s] <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
    endtask
    task automatic put(input logic [7:0] d, input logic st, b3);
        @(posedge sys_clk);
        spe_byte_en[0] <= 1'b1;
        spe_byte[0] <= d;
        spe_start[0] <= st;
        spe_b3[0] <= b3;
        @(posedge sys_clk);
        spe_byte_en[0] <= 1'b0;
        spe_start[0] <= 1'b0;
        spe_b3[0] <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] j1, b3);
        @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        put(j1, 1'b1, 1'b0);
        put(b3, 1'b0, 1'b1);
        par = j1 ^ b3;
        repeat (80) @(posedge sys_clk);
    endtask
    task automatic t_lop();
        rep(0, 0, 0, 0, 0, 0, 7);
        rep(0, 1, 10'h05a, 0, 0, 0, 1);
        rep(0, 0, 0, 0, 0, 0, 7);
        chk(pointer_loss_flag[0], 0, "lop early");
        rep(0, 0, 0, 0, 0, 0, 1);
        chk(pointer_loss_flag[0], 1, "lop set");
        rep(0, 1, 10'h05a, 0, 0, 0, 2);
        chk(pointer_loss_flag[0], 1, "lop cleared early");
        rep(0, 1, 10'h05a, 0, 0, 0, 1);
        chk(pointer_loss_flag[0], 0, "lop clear");
        rep(0, 1, 10'h05a, 1, 0, 0, 8);
        chk(pointer_loss_flag[0], 1, "lop ndf set");
        rep(0, 1, 10'h05a, 0, 0, 0, 3);
    endtask
    task automatic t_ais();
        rep(2, 0, 10'h3ff, 0, 1, 0, 2);
        chk(ais[2], 0, "ais early");
        rep(2, 0, 10'h3ff, 0, 1, 0, 1);
        chk(ais[2], 1, "ais set");
        rep(2, 1, 10'h100, 1, 0, 0, 1);
        chk(ais[2], 0, "ais ndf clear");
        rep(2, 0, 10'h3ff, 0, 1, 0, 3);
        rep(2, 1, 10'h100, 0, 0, 0, 2);
        chk(ais[2], 1, "ais cleared early");
        rep(2, 1, 10'h100, 0, 0, 0, 1);
        chk(ais[2], 0, "ais clear");
    endtask
    task automatic t_ferf();
        rep(1, 1, 10'h010, 0, 0, 1, 4);
        rep(1, 1, 10'h010, 0, 0, 0, 1);
        rep(1, 1, 10'h010, 0, 0, 1, 4);
        chk(ferf[1], 0, "ferf early");
        rep(1, 1, 10'h010, 0, 0, 1, 1);
        chk(ferf[1], 1, "ferf set");
        rep(1, 1, 10'h010, 0, 0, 0, 4);
        chk(ferf[1], 1, "ferf cleared early");
        rep(1, 1, 10'h010, 0, 0, 0, 1);
        chk(ferf[1], 0, "ferf clear");
    endtask
    task automatic t_parity();
        int n;
        n = 0;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge sys_clk);
            #1 n += (ovh[0] && !u_ppm_collector.ovh_q);
        end
        chk(n[8:0], 9'(40 / (2 * HALF)), "overhead rate");
        frame(8'h5a, 8'h00);
        frame(8'h3c, par ^ 8'h07);
        chk(pcnt, 3, "bit mode count");
        repeat (600) @(posedge sys_clk);
        chk(slots, 9'h007, "serial group");
        frame(8'h11, par);
        chk(pcnt, 0, "clean frame");
        block_mode <= 1'b1;
        frame(8'h22, par ^ 8'hff);
        chk(pcnt, 1, "block mode");
        block_mode <= 1'b0;
        frame(8'h33, par ^ 8'hff);
        chk(pcnt, 8, "bit mode eight");
    endtask
    task automatic t_modes();
        logic [2:0] acc;
        foreach (acc[k])
        begin
            if (k == 0)
                continue;
            mode <= (k == 1) ? PPM_MODE_STS1 : PPM_MODE_STS3C;
            acc = 3'h0;
            rep(1, 0, 0, 0, 1, 1, 8);
            rep(2, 0, 0, 0, 1, 1, 8);
            acc = {1'b0, pointer_loss_flag[2:1] | ais[2:1] | ovh[2:1] | mark[2:1] |
                   ferf[2:1] | perr[2:1]};
            chk(acc, 0, "idle streams");
        end
        rep(0, 0, 10'h3ff, 0, 1, 0, 3);
        chk(ais[0], 1, "ais single mode");
        ext_term_en <= 1'b1;
        acc = 3'h0;
        repeat (3) @(posedge sys_clk);
        repeat (40)
        begin
            @(posedge sys_clk);
            acc[0] = acc[0] | (|{ovh, mark, perr, pointer_loss_flag, ais, ferf, serial_alarm_out});
        end
        chk(acc, 0, "termination");
        ext_term_en <= 1'b0;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        stop_test();
    end
    initial
    begin
        {rst, block_mode, ext_term_en, clr} = 4'h8;
        mode = PPM_MODE_3XSTS1;
        line_clk_en = 1'b1;
        {frame_tick, ptr_valid, new_data_flag, ptr_ones} = 12'h000;
        {spe_byte_en, spe_start, spe_b3} = 9'h000;
        ptr_value = '0;
        g1_byte = '0;
        spe_byte = '0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk({pointer_loss_flag, ais, ferf}, 0, "reset state");
        t_lop();
        t_ais();
        t_ferf();
        t_parity();
        t_modes();
        stop_test();
    end
endmodule
